// ---- verilog/sdc_pkg.sv ----
// Constants, register map and carrier types for the SDI demo status and control block.
package sdc_pkg;
   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] HBDIV_OFS = 8'h08;
   localparam logic [7:0] ERRS_OFS = 8'h0C;
   localparam int ADDR_W = 8;

   // Values after reset, and the full count of the age counter.
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] HBDIV_RESET = 32'h0000_0010;
   localparam logic [3:0] ERRS_RESET = 4'h0;
   localparam logic [1:0] AGE_FULL = 2'h3;

   // Control register fields.
   localparam int CTRL_OVR_BIT = 0;
   localparam int CTRL_STD_LSB = 1;
   localparam int CTRL_CLR_BIT = 3;

   // Status register fields above the receiver status word.
   localparam int ST_TXSTD_LSB = 13;
   localparam int ST_HEART_BIT = 15;
   localparam int ST_SYSRST_BIT = 16;
   localparam int ST_CLR_BIT = 17;

   // Position of the four error flags inside the receiver status word.
   localparam int ERR_LSB = 7;

   // Video standard codes, shared by receive, transmit and switch settings.
   localparam logic [1:0] STD_SD = 2'h0;
   localparam logic [1:0] STD_HD = 2'h1;
   localparam logic [1:0] STD_3GA = 2'h3;
   localparam logic [1:0] STD_3GB = 2'h2;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Receiver and extractor status, most significant field first.
   typedef struct packed {
      logic [1:0] rx_std;
      logic aud_pkt_err;
      logic cs_crc_err;
      logic anc_par_err;
      logic anc_csum_err;
      logic frame_lock;
      logic trs_lock;
      logic align_lock;
      logic [3:0] grp;
   } sdc_rx_status_t;

   // User switch bank: system reset, status clear, standard select.
   typedef struct packed {
      logic sys_reset;
      logic status_clr;
      logic [1:0] std;
   } sdc_switch_t;
endpackage

// ---- verilog/sdc_sync.sv ----
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module sdc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule

// ---- verilog/sdc_status_top.sv ----
// Indicator and switch decode logic of the SDI audio demo, with an AXI4-Lite register slave.
// Functional notes
// - Four group LEDs follow the presence of audio groups 1 to 4 in the incoming audio.
// - The alignment LED is lit while the receiver reports word alignment lock.
// - The timing-reference LED is lit while the receiver reports TRS lock.
// - The frame LED is lit while the receiver reports frame lock.
// - The heartbeat LED toggles from the recovered clock so it blinks while that clock runs.
// - Ancillary checksum and parity failures each have their own LED.
// - Channel status CRC and audio packet failures each have their own LED.
// - The receive standard LEDs show 00 SD, 01 HD, 11 3G level A, 10 3G level B.
// - The transmit standard LEDs show the pattern generator standard in the same code.
// - One switch resets the system, a second clears the extractor status, the other two form the standard setting.
// - A two-bit switch setting, or the control register standard field while its override bit is set, selects the generated standard for both transmitters.
// - The selected standard enables groups 1, 1-2, 1-3 or 1-4 for codes 00, 01, 11, 10.
// - Logic on the oversampling clock is an independent domain reached only through synchronisers.
`timescale 1ns/1ps
module sdc_status_top #(
   parameter int HB_W = 16
) (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire sdc_pkg::sdc_rx_status_t RX_STATUS,
   input wire logic RX_CLK_DIV,
   input wire sdc_pkg::sdc_switch_t SWITCHES,
   output logic [3:0] LED_GROUP,
   output logic LED_ALIGN,
   output logic LED_TRS,
   output logic LED_FRAME,
   output logic LED_HEART,
   output logic LED_ANC_CSUM,
   output logic LED_ANC_PARITY,
   output logic LED_CS_CRC,
   output logic LED_AUD_PKT,
   output logic [1:0] LED_RX_STD,
   output logic [1:0] LED_TX_STD,
   output logic SYS_RESET_OUT,
   output logic EXT_STATUS_CLR,
   output logic [1:0] TX_STD_SEL,
   output logic [3:0] EMBED_GROUP_EN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   // Embed enables for a standard code: one more group per step of the code sequence.
   function automatic logic [3:0] embed_decode(input logic [1:0] std);
      case (std)
         sdc_pkg::STD_SD: embed_decode = 4'h1;
         sdc_pkg::STD_HD: embed_decode = 4'h3;
         sdc_pkg::STD_3GA: embed_decode = 4'h7;
         default: embed_decode = 4'hF;
      endcase
   endfunction

   // Applies byte enables to a 32-bit register.
   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         strb_merge[8*i +: 8] = st[i] ? wd[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   sdc_pkg::sdc_rx_status_t rx_s;
   sdc_pkg::sdc_switch_t sw_s;
   logic hb_s;

   sdc_sync #(.W($bits(sdc_pkg::sdc_rx_status_t))) u_rx_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .d(RX_STATUS),
      .q(rx_s)
   );
   sdc_sync #(.W($bits(sdc_pkg::sdc_switch_t))) u_sw_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .d(SWITCHES),
      .q(sw_s)
   );
   sdc_sync #(.W(1)) u_hb_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .d(RX_CLK_DIV),
      .q(hb_s)
   );

   // Register file state.
   logic [31:0] ctrl_reg, ctrl_next;
   logic [31:0] hbdiv_reg, hbdiv_next;
   logic [3:0] errs_reg, errs_next;

   // Indicator and control output state.
   sdc_pkg::sdc_rx_status_t led_reg, led_next;
   logic [1:0] tx_std_reg, tx_std_next;
   logic [3:0] embed_reg, embed_next;
   logic sys_rst_reg, sys_rst_next;
   logic clr_reg, clr_next;
   logic heart_reg, heart_next;
   logic hb_prev_reg, hb_prev_next;
   logic [HB_W-1:0] hb_cnt_reg, hb_cnt_next;

   // AXI slave state.
   logic aw_have_reg, aw_have_next;
   logic w_have_reg, w_have_next;
   logic [7:0] waddr_reg, waddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;

   logic [31:0] status_word;
   logic wr_fire;
   logic hb_edge;
   logic [HB_W-1:0] hb_limit;

   always_comb begin
      status_word = '0;
      status_word[$bits(sdc_pkg::sdc_rx_status_t)-1:0] = led_reg;
      status_word[sdc_pkg::ST_TXSTD_LSB +: 2] = tx_std_reg;
      status_word[sdc_pkg::ST_HEART_BIT] = heart_reg;
      status_word[sdc_pkg::ST_SYSRST_BIT] = sys_rst_reg;
      status_word[sdc_pkg::ST_CLR_BIT] = clr_reg;
   end

   // AXI write and read channels.
   always_comb begin
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      wr_fire = 1'b0;
      if (S_AXI_AWVALID && awready_reg) begin
         aw_have_next = 1'b1;
         waddr_next = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wready_reg) begin
         w_have_next = 1'b1;
         wdata_next = S_AXI_WDATA;
         wstrb_next = S_AXI_WSTRB;
      end
      if (bvalid_reg && S_AXI_BREADY) begin
         bvalid_next = 1'b0;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         wr_fire = 1'b1;
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         case (waddr_reg[7:2])
            sdc_pkg::CTRL_OFS[7:2], sdc_pkg::HBDIV_OFS[7:2], sdc_pkg::ERRS_OFS[7:2]: bresp_next = sdc_pkg::RESP_OKAY;
            default: bresp_next = sdc_pkg::RESP_SLVERR;
         endcase
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next = !w_have_next && !bvalid_next;
      if (S_AXI_ARVALID && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rresp_next = sdc_pkg::RESP_OKAY;
         case (S_AXI_ARADDR[7:2])
            sdc_pkg::STATUS_OFS[7:2]: rdata_next = status_word;
            sdc_pkg::CTRL_OFS[7:2]: rdata_next = ctrl_reg;
            sdc_pkg::HBDIV_OFS[7:2]: rdata_next = hbdiv_reg;
            sdc_pkg::ERRS_OFS[7:2]: rdata_next = {28'h000_0000, errs_reg};
            default: begin
               rdata_next = '0;
               rresp_next = sdc_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      // A new read address is taken whenever no read answer is pending.
      arready_next = !rvalid_next;
   end

   // Registers, sticky error flags and the self-clearing status clear bit.
   always_comb begin
      ctrl_next = ctrl_reg;
      hbdiv_next = hbdiv_reg;
      errs_next = errs_reg;
      ctrl_next[sdc_pkg::CTRL_CLR_BIT] = 1'b0;
      if (wr_fire && waddr_reg[7:2] == sdc_pkg::CTRL_OFS[7:2]) begin
         ctrl_next = strb_merge(ctrl_reg, wdata_reg, wstrb_reg);
      end
      if (wr_fire && waddr_reg[7:2] == sdc_pkg::HBDIV_OFS[7:2]) begin
         hbdiv_next = strb_merge(hbdiv_reg, wdata_reg, wstrb_reg);
      end
      if (wr_fire && waddr_reg[7:2] == sdc_pkg::ERRS_OFS[7:2] && wstrb_reg[0]) begin
         errs_next = errs_reg & ~wdata_reg[3:0];
      end
      errs_next = errs_next | rx_s[sdc_pkg::ERR_LSB +: 4];
   end

   // Indicators, switch decode and heartbeat.
   always_comb begin
      hb_limit = hbdiv_reg[HB_W-1:0];
      hb_edge = hb_s ^ hb_prev_reg;
      hb_prev_next = hb_s;
      hb_cnt_next = hb_cnt_reg;
      heart_next = heart_reg;
      // toggle after a set number of recovered clock edges.
      if (hb_edge) begin
         if (hb_cnt_reg + 1'b1 >= hb_limit) begin
            hb_cnt_next = '0;
            heart_next = !heart_reg;
         end else begin
            hb_cnt_next = hb_cnt_reg + 1'b1;
         end
      end
      led_next = rx_s;
      // switch or software override selects the standard.
      if (ctrl_reg[sdc_pkg::CTRL_OVR_BIT]) begin
         tx_std_next = ctrl_reg[sdc_pkg::CTRL_STD_LSB +: 2];
      end else begin
         tx_std_next = sw_s.std;
      end
      embed_next = embed_decode(tx_std_next);
      sys_rst_next = sw_s.sys_reset;
      clr_next = sw_s.status_clr | ctrl_reg[sdc_pkg::CTRL_CLR_BIT];
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         ctrl_reg <= sdc_pkg::CTRL_RESET;
         hbdiv_reg <= sdc_pkg::HBDIV_RESET;
         errs_reg <= sdc_pkg::ERRS_RESET;
         led_reg <= '0;
         tx_std_reg <= sdc_pkg::STD_SD;
         embed_reg <= '0;
         sys_rst_reg <= 1'b0;
         clr_reg <= 1'b0;
         heart_reg <= 1'b0;
         hb_prev_reg <= 1'b0;
         hb_cnt_reg <= '0;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= sdc_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= sdc_pkg::RESP_OKAY;
      end else begin
         ctrl_reg <= ctrl_next;
         hbdiv_reg <= hbdiv_next;
         errs_reg <= errs_next;
         led_reg <= led_next;
         tx_std_reg <= tx_std_next;
         embed_reg <= embed_next;
         sys_rst_reg <= sys_rst_next;
         clr_reg <= clr_next;
         heart_reg <= heart_next;
         hb_prev_reg <= hb_prev_next;
         hb_cnt_reg <= hb_cnt_next;
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
      end
   end

   assign LED_GROUP = led_reg.grp;
   assign LED_ALIGN = led_reg.align_lock;
   assign LED_TRS = led_reg.trs_lock;
   assign LED_FRAME = led_reg.frame_lock;
   assign LED_HEART = heart_reg;
   assign LED_ANC_CSUM = led_reg.anc_csum_err;
   assign LED_ANC_PARITY = led_reg.anc_par_err;
   assign LED_CS_CRC = led_reg.cs_crc_err;
   assign LED_AUD_PKT = led_reg.aud_pkt_err;
   assign LED_RX_STD = led_reg.rx_std;
   // transmit standard LEDs follow the generator selection.
   assign LED_TX_STD = tx_std_reg;
   assign SYS_RESET_OUT = sys_rst_reg;
   assign EXT_STATUS_CLR = clr_reg;
   assign TX_STD_SEL = tx_std_reg;
   assign EMBED_GROUP_EN = embed_reg;
   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;

   // Cycles since reset release, saturating, so checks skip the pipeline fill.
   logic [1:0] age_reg, age_next;
   always_comb begin
      age_next = (age_reg == sdc_pkg::AGE_FULL) ? age_reg : age_reg + 2'h1;
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         age_reg <= '0;
      end else begin
         age_reg <= age_next;
      end
   end

   sequence hb_edge_s;
      hb_edge && (hb_cnt_reg + 1'b1 >= hb_limit);
   endsequence
   sequence heart_flip_s;
      LED_HEART != $past(LED_HEART);
   endsequence

   grp_led_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> LED_GROUP == $past(RX_STATUS.grp, 3)) else $error("group LED mismatch");
   align_led_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> LED_ALIGN == $past(RX_STATUS.align_lock, 3)) else $error("align LED mismatch");
   trs_led_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> LED_TRS == $past(RX_STATUS.trs_lock, 3)) else $error("TRS LED mismatch");
   frame_led_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> LED_FRAME == $past(RX_STATUS.frame_lock, 3)) else $error("frame LED mismatch");
   heart_flip_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      hb_edge_s |=> heart_flip_s) else $error("heartbeat did not toggle");
   heart_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      !hb_edge |=> $stable(LED_HEART)) else $error("heartbeat toggled without edge");
   anc_err_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> {LED_ANC_CSUM, LED_ANC_PARITY} ==
      {$past(RX_STATUS.anc_csum_err, 3), $past(RX_STATUS.anc_par_err, 3)}) else $error("ancillary LED mismatch");
   aud_err_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> {LED_CS_CRC, LED_AUD_PKT} ==
      {$past(RX_STATUS.cs_crc_err, 3), $past(RX_STATUS.aud_pkt_err, 3)}) else $error("audio error LED mismatch");
   rx_std_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> LED_RX_STD == $past(RX_STATUS.rx_std, 3)) else $error("rx standard LED mismatch");
   tx_std_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $past(ctrl_reg[sdc_pkg::CTRL_OVR_BIT]) |->
      LED_TX_STD == $past(ctrl_reg[sdc_pkg::CTRL_STD_LSB +: 2])) else $error("tx standard LED mismatch");
   sys_rst_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL |-> SYS_RESET_OUT == $past(SWITCHES.sys_reset, 3)) else $error("reset switch mismatch");
   std_sel_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg == sdc_pkg::AGE_FULL && !$past(ctrl_reg[sdc_pkg::CTRL_OVR_BIT]) |->
      TX_STD_SEL == $past(SWITCHES.std, 3)) else $error("standard select mismatch");
   embed_a: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      age_reg != 2'h0 |-> EMBED_GROUP_EN == {TX_STD_SEL == sdc_pkg::STD_3GB, TX_STD_SEL[1],
      TX_STD_SEL != sdc_pkg::STD_SD, 1'b1}) else $error("embed decode mismatch");
endmodule

// ---- sim/sdc_rx_model.sv ----
// Behavioural receiver and audio extractor that drive the status levels and the divided recovered clock.
`timescale 1ns/1ps
module sdc_rx_model (
   input wire sdc_pkg::sdc_rx_status_t stat_set,
   input wire logic run,
   output sdc_pkg::sdc_rx_status_t rx_status,
   output logic rx_clk_div
);
   // unrelated status timing
   // Status levels change well away from the system clock edge, as they would from the recovered domain.
   assign #7 rx_status = stat_set;

   // recovered clock source
   // The 0.3 ns start offset keeps every edge off the system clock edge, and the clock stands still when stopped.
   initial begin
      rx_clk_div = 1'b0;
      #0.3;
      forever begin
         #212.5;
         if (run === 1'b1) rx_clk_div = ~rx_clk_div;
      end
   end
endmodule

// ---- sim/tb_sdi_demo_status_control.sv ----
// Self-checking bench for the SDI demo status and control block.
`timescale 1ns/1ps
module tb_sdi_demo_status_control;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   sdc_pkg::sdc_rx_status_t stat_set = '0;
   sdc_pkg::sdc_rx_status_t rx_status;
   sdc_pkg::sdc_switch_t switches = '0;
   logic rx_run = 1'b0;
   logic rx_clk_div, led_align, led_trs, led_frame, led_heart, led_anc_csum, led_anc_parity;
   logic led_cs_crc, led_aud_pkt, sys_reset_out, ext_status_clr;
   logic [3:0] led_group, embed_group_en;
   logic [1:0] led_rx_std, led_tx_std, tx_std_sel, s_bresp, s_rresp;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, s_rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, hb_prev, rx_prev, hb_on = 1'b0;
   int bad_count = 0, check_count = 0, clr_n = 0, hb_n = 0, rx_n = 0;
   logic [12:0] p, prev_p;
   wire [12:0] led_word = {led_rx_std, led_aud_pkt, led_cs_crc, led_anc_parity, led_anc_csum,
                           led_frame, led_trs, led_align, led_group};

   always #25 core_clk = ~core_clk;

   sdc_rx_model u_rx (.stat_set(stat_set), .run(rx_run), .rx_status(rx_status), .rx_clk_div(rx_clk_div));

   sdc_status_top #(.HB_W(16)) u_dut (
      .CORE_CLK(core_clk), .RESET_N(reset_n), .RX_STATUS(rx_status), .RX_CLK_DIV(rx_clk_div),
      .SWITCHES(switches), .LED_GROUP(led_group), .LED_ALIGN(led_align), .LED_TRS(led_trs),
      .LED_FRAME(led_frame), .LED_HEART(led_heart), .LED_ANC_CSUM(led_anc_csum),
      .LED_ANC_PARITY(led_anc_parity), .LED_CS_CRC(led_cs_crc), .LED_AUD_PKT(led_aud_pkt),
      .LED_RX_STD(led_rx_std), .LED_TX_STD(led_tx_std), .SYS_RESET_OUT(sys_reset_out),
      .EXT_STATUS_CLR(ext_status_clr), .TX_STD_SEL(tx_std_sel), .EMBED_GROUP_EN(embed_group_en),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(s_awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(s_wready),
      .S_AXI_BRESP(s_bresp), .S_AXI_BVALID(s_bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(s_arready),
      .S_AXI_RDATA(s_rdata), .S_AXI_RRESP(s_rresp), .S_AXI_RVALID(s_rvalid), .S_AXI_RREADY(rready)
   );

   // Pulse and toggle counters run beside the main sequence so that no event is missed.
   always @(posedge core_clk) begin
      hb_prev <= led_heart;
      rx_prev <= rx_clk_div;
      if (ext_status_clr === 1'b1) clr_n++;
      if (hb_on && led_heart !== hb_prev) hb_n++;
      if (hb_on && rx_clk_div !== rx_prev) rx_n++;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic timeout_hit();
      bad_count++;
      $display("timeout at %0t", $time);
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic b_seen;
      @(posedge core_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      b_seen = 1'b0;
      while (!b_seen && n < 50) begin
         @(posedge core_clk);
         n++;
         if (awvalid === 1'b1 && s_awready === 1'b1) awvalid <= 1'b0;
         if (wvalid === 1'b1 && s_wready === 1'b1) wvalid <= 1'b0;
         if (s_bvalid === 1'b1) b_seen = 1'b1;
      end
      if (!b_seen) timeout_hit();
      bready <= 1'b0;
      chk(32'(s_bresp), 32'(er));
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      logic r_seen;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      r_seen = 1'b0;
      while (!r_seen && n < 50) begin
         @(posedge core_clk);
         n++;
         if (arvalid === 1'b1 && s_arready === 1'b1) arvalid <= 1'b0;
         if (s_rvalid === 1'b1) r_seen = 1'b1;
      end
      if (!r_seen) timeout_hit();
      rready <= 1'b0;
      d = s_rdata;
      chk(32'(s_rresp), 32'(er));
   endtask

   function automatic logic [3:0] emb(input logic [1:0] s);
      case (s)
         2'b00: return 4'h1;
         2'b01: return 4'h3;
         2'b11: return 4'h7;
         default: return 4'hF;
      endcase
   endfunction

   initial begin
      repeat (12) @(posedge core_clk);
      reset_n <= 1'b1;
      cycles(3);
      axi_read(sdc_pkg::CTRL_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, sdc_pkg::CTRL_RESET);
      axi_read(sdc_pkg::HBDIV_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, sdc_pkg::HBDIV_RESET);
      axi_read(sdc_pkg::ERRS_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, 32'(sdc_pkg::ERRS_RESET));
      axi_read(8'h10, rd, sdc_pkg::RESP_SLVERR);
      chk(rd, 32'h0000_0000);
      axi_write(sdc_pkg::STATUS_OFS, 32'hFFFF_FFFF, sdc_pkg::RESP_SLVERR);
      $display("test registers done");

      // Walking ones over every status field, then all ones and all zeros for the last two codes.
      prev_p = 13'h0000;
      for (int i = 0; i < 15; i++) begin
         p = (i < 13) ? 13'h0001 << i : ((i == 13) ? 13'h1FFF : 13'h0000);
         @(posedge core_clk);
         stat_set <= sdc_pkg::sdc_rx_status_t'(p);
         cycles(2);
         @(negedge core_clk);
         chk(32'(led_word), 32'(prev_p));
         cycles(2);
         @(negedge core_clk);
         chk(32'(led_word), 32'(p));
         axi_read(sdc_pkg::STATUS_OFS, rd, sdc_pkg::RESP_OKAY);
         chk(rd & 32'h0000_1FFF, 32'(p));
         prev_p = p;
      end
      axi_read(sdc_pkg::ERRS_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, 32'h0000_000F);
      axi_write(sdc_pkg::ERRS_OFS, 32'h0000_0005, sdc_pkg::RESP_OKAY);
      axi_read(sdc_pkg::ERRS_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, 32'h0000_000A);
      $display("test indicators done");

      for (int j = 0; j < 4; j++) begin
         @(posedge core_clk);
         switches <= '{sys_reset: 1'b0, status_clr: 1'b0, std: 2'(j)};
         cycles(5);
         chk(32'(tx_std_sel), 32'(j));
         chk(32'(led_tx_std), 32'(j));
         chk(32'(embed_group_en), 32'(emb(2'(j))));
      end
      @(posedge core_clk);
      switches <= '{sys_reset: 1'b1, status_clr: 1'b1, std: 2'b00};
      cycles(5);
      chk(32'({sys_reset_out, ext_status_clr}), 32'h0000_0003);
      axi_read(sdc_pkg::STATUS_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd & 32'h0003_6000, 32'h0003_0000);
      switches <= '{sys_reset: 1'b0, status_clr: 1'b0, std: 2'b00};
      cycles(5);
      chk(32'({sys_reset_out, ext_status_clr}), 32'h0000_0000);
      $display("test switches done");

      axi_write(sdc_pkg::CTRL_OFS, 32'h0000_0005, sdc_pkg::RESP_OKAY);
      cycles(3);
      chk(32'(tx_std_sel), 32'h0000_0002);
      chk(32'(embed_group_en), 32'h0000_000F);
      @(negedge core_clk);
      clr_n = 0;
      axi_write(sdc_pkg::CTRL_OFS, 32'h0000_000D, sdc_pkg::RESP_OKAY);
      cycles(5);
      chk(32'(clr_n), 32'h0000_0001);
      axi_read(sdc_pkg::CTRL_OFS, rd, sdc_pkg::RESP_OKAY);
      chk(rd, 32'h0000_0005);
      axi_write(sdc_pkg::CTRL_OFS, 32'h0000_0000, sdc_pkg::RESP_OKAY);
      $display("test control done");

      // Toggle counts are compared with the recovered clock edges seen in the same window.
      for (int k = 0; k < 3; k++) begin
         axi_write(sdc_pkg::HBDIV_OFS, (k == 0) ? 32'h0000_0001 : 32'h0000_0004, sdc_pkg::RESP_OKAY);
         rx_run <= (k < 2);
         cycles(10);
         @(negedge core_clk);
         hb_n = 0;
         rx_n = 0;
         hb_on = 1'b1;
         cycles(400);
         @(negedge core_clk);
         hb_on = 1'b0;
         if (k == 0) chk(32'(hb_n >= rx_n - 1 && hb_n <= rx_n + 1 && rx_n > 50), 32'h0000_0001);
         if (k == 1) chk(32'(hb_n >= rx_n / 4 - 1 && hb_n <= rx_n / 4 + 1), 32'h0000_0001);
         if (k == 2) chk(32'(hb_n), 32'h0000_0000);
      end
      $display("test heartbeat done");
      final_report();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      timeout_hit();
   end
endmodule
